// >>> rtl/iicr_pkg.sv
// Package: register map, field layout, reset values and shared types of the bus controller.
package iicr_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_RATE   = 8'h00;
   localparam logic [7:0] OFF_CTRL   = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_MASK   = 8'h0C;
   localparam logic [7:0] OFF_DATA   = 8'h10;

   // Control register fields
   localparam int CTRL_EN  = 7;
   localparam int CTRL_IE  = 6;
   localparam int CTRL_MS  = 5;
   localparam int CTRL_DIR = 4;
   localparam int CTRL_ACK = 3;
   localparam int CTRL_RS  = 2;

   // Rate register fields
   localparam int RATE_SCALE_LSB = 6;
   localparam int RATE_INDEX_LSB = 0;

   // Status and mask fields
   localparam int ST_DONE  = 0;
   localparam int ST_ARB   = 1;
   localparam int ST_BUSY  = 4;
   localparam int ST_RXACK = 5;

   // Reset values
   localparam logic [7:0] RST_RATE = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [1:0] RST_MASK = 2'h0;

   // Scale field encodings, as shift amounts
   localparam logic [1:0] SCALE_X1 = 2'h0;
   localparam logic [1:0] SCALE_X2 = 2'h1;
   localparam logic [1:0] SCALE_X4 = 2'h2;

   // First row of the rate table held here
   localparam logic [5:0] INDEX_BASE = 6'h20;

   // Bit number of the acknowledge in a byte frame, after the eight data bits
   localparam logic [3:0] ACK_BIT = 4'h8;

   // One row of the rate table
   typedef struct packed {
      logic [11:0] div;
      logic [9:0]  sda_hold;
      logic [10:0] start_hold;
      logic [10:0] stop_hold;
   } iicr_rate_s;

   // Open-drain pin drive, enable low while pulling the wire
   typedef struct packed {
      logic scl_o;
      logic scl_oe_n;
      logic sda_o;
      logic sda_oe_n;
   } iicr_pins_s;

   // Bus engine states
   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_START     = 4'h1,
      ST_WAIT      = 4'h2,
      ST_LOW       = 4'h3,
      ST_HIGH      = 4'h4,
      ST_STOP_LOW  = 4'h5,
      ST_STOP_HOLD = 4'h6,
      ST_RS_LOW    = 4'h7,
      ST_RS_HIGH   = 4'h8
   } iicr_state_e;

endpackage

// >>> rtl/iicr_rate_rom.sv
// Rate lookup: clock-rate index to SCL divider and hold counts.
`timescale 1ns/1ps
module iicr_rate_rom (
   // Selected index
   input  wire logic [5:0]         index,
   // Table row
   output iicr_pkg::iicr_rate_s    row
);

   // Row number within the held half of the table
   logic [4:0] sel;

   // Lower indices fall back onto the first held row
   always_comb begin
      if (index < iicr_pkg::INDEX_BASE) begin
         sel = 5'h00;
      end else begin
         sel = index[4:0];
      end
   end

   always_comb begin
      case (sel)
         5'h00: row = '{12'd160,  10'd17,  11'd78,   11'd81};
         5'h01: row = '{12'd192,  10'd17,  11'd94,   11'd97};
         5'h02: row = '{12'd224,  10'd33,  11'd110,  11'd113};
         5'h03: row = '{12'd256,  10'd33,  11'd126,  11'd129};
         5'h04: row = '{12'd288,  10'd49,  11'd142,  11'd145};
         5'h05: row = '{12'd320,  10'd49,  11'd158,  11'd161};
         5'h06: row = '{12'd384,  10'd65,  11'd190,  11'd193};
         5'h07: row = '{12'd480,  10'd65,  11'd238,  11'd241};
         5'h08: row = '{12'd320,  10'd33,  11'd158,  11'd161};
         5'h09: row = '{12'd384,  10'd33,  11'd190,  11'd193};
         5'h0A: row = '{12'd448,  10'd65,  11'd222,  11'd225};
         5'h0B: row = '{12'd512,  10'd65,  11'd254,  11'd257};
         5'h0C: row = '{12'd576,  10'd97,  11'd286,  11'd289};
         5'h0D: row = '{12'd640,  10'd97,  11'd318,  11'd321};
         5'h0E: row = '{12'd768,  10'd129, 11'd382,  11'd385};
         5'h0F: row = '{12'd960,  10'd129, 11'd478,  11'd481};
         5'h10: row = '{12'd640,  10'd65,  11'd318,  11'd321};
         5'h11: row = '{12'd768,  10'd65,  11'd382,  11'd385};
         5'h12: row = '{12'd896,  10'd129, 11'd446,  11'd449};
         5'h13: row = '{12'd1024, 10'd129, 11'd510,  11'd513};
         5'h14: row = '{12'd1152, 10'd193, 11'd574,  11'd577};
         5'h15: row = '{12'd1280, 10'd193, 11'd638,  11'd641};
         5'h16: row = '{12'd1536, 10'd257, 11'd766,  11'd769};
         5'h17: row = '{12'd1920, 10'd257, 11'd958,  11'd961};
         5'h18: row = '{12'd1280, 10'd129, 11'd638,  11'd641};
         5'h19: row = '{12'd1536, 10'd129, 11'd766,  11'd769};
         5'h1A: row = '{12'd1792, 10'd257, 11'd894,  11'd897};
         5'h1B: row = '{12'd2048, 10'd257, 11'd1022, 11'd1025};
         5'h1C: row = '{12'd2304, 10'd385, 11'd1150, 11'd1153};
         5'h1D: row = '{12'd2560, 10'd385, 11'd1278, 11'd1281};
         5'h1E: row = '{12'd3072, 10'd513, 11'd1534, 11'd1537};
         5'h1F: row = '{12'd3840, 10'd513, 11'd1918, 11'd1921};
         default: row = '{12'd160, 10'd17, 11'd78, 11'd81};
      endcase
   end

endmodule

// >>> rtl/iicr_ctrl.sv
// Bus controller top: APB registers, rate timing and the master bus engine.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module iicr_ctrl (
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               srst,
   // APB slave
   input  wire logic [7:0]         paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Bus line levels as seen on the wires
   input  wire logic               scl_i,
   input  wire logic               sda_i,
   // Bus line drive
   output iicr_pkg::iicr_pins_s    pins,
   // Interrupt request, level
   output logic                    irq
);

   // Software-visible state, plus the repeat request and master select history
   logic [7:0]              rate_r;        // Scale and index
   logic [7:0]              ctrl_r;        // Control one, repeat bit never stored
   logic [1:0]              status_r;      // Sticky events
   logic [1:0]              mask_r;        // Interrupt mask
   logic [7:0]              tx_data_r;     // Byte to send
   logic [7:0]              rx_data_r;     // Last byte received
   logic                    rxack_r;       // Ack seen after a sent byte
   logic [31:0]             prdata_r;      // Read data captured at setup
   logic                    slverr_r;      // Unmapped address at setup
   logic                    rs_req_r;      // Repeated start pending
   logic                    ms_prev_r;     // Master select one cycle ago

   // Engine state
   iicr_pkg::iicr_state_e   state_r;
   logic [15:0]             cnt_r;         // Phase timer
   logic [3:0]              bit_r;         // Bit within byte frame
   logic [7:0]              shift_r;       // Shift register
   logic                    scl_low_r;     // Pulling SCL low
   logic                    sda_low_r;     // Pulling SDA low
   logic                    done_ev_r;     // Byte finished, one cycle
   logic                    arb_ev_r;      // Arbitration lost on the wire, one cycle

   // Decoded access
   logic                    acc;           // Access phase
   logic                    wr;
   logic                    rd;
   logic                    setup;
   logic                    mapped;
   logic                    rs_write;      // Repeat bit written as one
   logic                    rs_bad;        // Repeat asked at the wrong time
   logic                    go;            // Start the next byte
   logic                    arb_any;       // Any loss of arbitration

   // Timing derived from the table
   iicr_pkg::iicr_rate_s    row;
   logic [1:0]              shamt;
   logic [15:0]             half_c;
   logic [15:0]             sdah_c;
   logic [15:0]             starth_c;
   logic [15:0]             stoph_c;
   logic                    drive_bit;     // Level wanted on SDA this bit
   logic                    en;
   logic                    ms;
   logic                    tx;

   assign en = ctrl_r[iicr_pkg::CTRL_EN];
   assign ms = ctrl_r[iicr_pkg::CTRL_MS];
   assign tx = ctrl_r[iicr_pkg::CTRL_DIR];

   // Table lookup
   iicr_rate_rom u_rom (
      .index (rate_r[5:0]),
      .row   (row)
   );

   always_comb begin
      case (rate_r[7:6])
         iicr_pkg::SCALE_X1: shamt = 2'h0;
         iicr_pkg::SCALE_X2: shamt = 2'h1;
         iicr_pkg::SCALE_X4: shamt = 2'h2;
         default:            shamt = 2'h0;   // Reserved code runs as factor one
      endcase
   end

   always_comb begin
      half_c   = 16'(({4'h0, row.div} << shamt) >> 1);
      sdah_c   = 16'({6'h00, row.sda_hold} << shamt);
      starth_c = 16'({5'h00, row.start_hold} << shamt);
      stoph_c  = 16'({5'h00, row.stop_hold} << shamt);
   end

   // APB decode; zero wait states, read data prepared at setup
   assign setup    = psel & ~penable;
   assign acc      = psel & penable;
   assign wr       = acc & pwrite;
   assign rd       = acc & ~pwrite;
   assign pready   = 1'b1;
   assign prdata   = prdata_r;
   assign pslverr  = acc & slverr_r;
   assign mapped   = (paddr == iicr_pkg::OFF_RATE) | (paddr == iicr_pkg::OFF_CTRL) |
                     (paddr == iicr_pkg::OFF_STATUS) | (paddr == iicr_pkg::OFF_MASK) |
                     (paddr == iicr_pkg::OFF_DATA);
   assign rs_write = wr & ~slverr_r & (paddr == iicr_pkg::OFF_CTRL) & pwdata[iicr_pkg::CTRL_RS];

   assign rs_bad  = rs_write & ~(en & ms & (state_r == iicr_pkg::ST_WAIT));
   assign arb_any = rs_bad | arb_ev_r;

   assign go = (state_r == iicr_pkg::ST_WAIT) & (paddr == iicr_pkg::OFF_DATA) &
               ((wr & tx) | (rd & ~tx));

   // Read mux sampled in the setup cycle so prdata comes from a flop
   always_ff @(posedge mclk) begin
      if (srst) begin
         prdata_r <= 32'h0000_0000;
         slverr_r <= 1'b0;
      end else if (setup) begin
         slverr_r <= ~mapped;
         case (paddr)
            iicr_pkg::OFF_RATE:   prdata_r <= {24'h000000, rate_r};
            iicr_pkg::OFF_CTRL:   prdata_r <= {24'h000000, ctrl_r & 8'hFB};
            iicr_pkg::OFF_STATUS: prdata_r <= {26'h0000000, rxack_r, (state_r != iicr_pkg::ST_IDLE),
                                               2'h0, status_r};
            iicr_pkg::OFF_MASK:   prdata_r <= {30'h00000000, mask_r};
            iicr_pkg::OFF_DATA:   prdata_r <= {24'h000000, rx_data_r};
            default:              prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // Rate, mask and transmit byte
   always_ff @(posedge mclk) begin
      if (srst) begin
         rate_r    <= iicr_pkg::RST_RATE;
         mask_r    <= iicr_pkg::RST_MASK;
         tx_data_r <= 8'h00;
      end else if (wr) begin
         if (paddr == iicr_pkg::OFF_RATE) begin
            rate_r <= pwdata[7:0];
         end
         if (paddr == iicr_pkg::OFF_MASK) begin
            mask_r <= pwdata[1:0];
         end
         if (paddr == iicr_pkg::OFF_DATA) begin
            tx_data_r <= pwdata[7:0];
         end
      end
   end

   // Control one; hardware drops master select on arbitration loss
   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrl_r    <= iicr_pkg::RST_CTRL;
         ms_prev_r <= 1'b0;
      end else begin
         ms_prev_r <= ms;
         if (wr & (paddr == iicr_pkg::OFF_CTRL)) begin
            ctrl_r <= pwdata[7:0] & 8'hFB;
         end
         // Loss forces slave mode without a stop on the wire
         if (arb_any) begin
            ctrl_r[iicr_pkg::CTRL_MS] <= 1'b0;
         end
      end
   end

   // Repeated start request; taken by the engine from the wait state
   always_ff @(posedge mclk) begin
      if (srst) begin
         rs_req_r <= 1'b0;
      end else if (rs_write & ~rs_bad) begin
         rs_req_r <= 1'b1;
      end else if ((state_r == iicr_pkg::ST_RS_LOW) | ~en | arb_any) begin
         rs_req_r <= 1'b0;
      end
   end

   // Sticky status; a new event beats a same-cycle clear
   always_ff @(posedge mclk) begin
      if (srst) begin
         status_r <= 2'h0;
      end else begin
         if (wr & (paddr == iicr_pkg::OFF_STATUS)) begin
            status_r <= status_r & ~pwdata[1:0];
         end
         if (done_ev_r) begin
            status_r[iicr_pkg::ST_DONE] <= 1'b1;
         end
         if (arb_any) begin
            status_r[iicr_pkg::ST_ARB] <= 1'b1;
         end
      end
   end

   assign irq = ctrl_r[iicr_pkg::CTRL_IE] & |(status_r & mask_r);

   // Level for SDA in the current bit: data out, released, or ack control
   always_comb begin
      if (bit_r < iicr_pkg::ACK_BIT) begin
         drive_bit = tx ? shift_r[7] : 1'b1;
      end else begin
         drive_bit = tx ? 1'b1 : ctrl_r[iicr_pkg::CTRL_ACK];
      end
   end

   // Bus engine: phases, timers, shifting and line drive
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_r   <= iicr_pkg::ST_IDLE;
         cnt_r     <= 16'h0000;
         bit_r     <= 4'h0;
         shift_r   <= 8'h00;
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         done_ev_r <= 1'b0;
         arb_ev_r  <= 1'b0;
         rx_data_r <= 8'h00;
         rxack_r   <= 1'b0;
      end else if (~en | arb_any) begin
         state_r   <= iicr_pkg::ST_IDLE;
         cnt_r     <= 16'h0000;
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         done_ev_r <= 1'b0;
         arb_ev_r  <= 1'b0;
      end else begin
         done_ev_r <= 1'b0;
         arb_ev_r  <= 1'b0;
         case (state_r)
            iicr_pkg::ST_IDLE: begin
               cnt_r <= 16'h0000;
               if (ms & ~ms_prev_r) begin
                  sda_low_r <= 1'b1;
                  state_r   <= iicr_pkg::ST_START;
               end
            end
            iicr_pkg::ST_START: begin
               // SDA low with SCL high, held for the start count
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r + 16'h0001 >= starth_c) begin
                  scl_low_r <= 1'b1;
                  cnt_r     <= 16'h0000;
                  state_r   <= iicr_pkg::ST_WAIT;
               end
            end
            iicr_pkg::ST_WAIT: begin
               // SCL parked low between bytes
               cnt_r <= 16'h0000;
               if (go) begin
                  bit_r   <= 4'h0;
                  shift_r <= tx ? (pwdata[7:0] & {8{wr}}) | (tx_data_r & {8{~wr}}) : 8'hFF;
                  state_r <= iicr_pkg::ST_LOW;
               end else if (rs_req_r) begin
                  state_r <= iicr_pkg::ST_RS_LOW;
               end else if (~ms) begin
                  sda_low_r <= 1'b1;
                  state_r   <= iicr_pkg::ST_STOP_LOW;
               end
            end
            iicr_pkg::ST_LOW: begin
               cnt_r <= cnt_r + 16'h0001;
               // SDA changes only after the hold past the falling edge
               if (cnt_r + 16'h0001 == sdah_c) begin
                  sda_low_r <= ~drive_bit;
               end
               if (cnt_r + 16'h0001 >= half_c) begin
                  scl_low_r <= 1'b0;
                  cnt_r     <= 16'h0000;
                  state_r   <= iicr_pkg::ST_HIGH;
               end
            end
            iicr_pkg::ST_HIGH: begin
               // Timer waits while another party stretches SCL low
               if (scl_i) begin
                  cnt_r <= cnt_r + 16'h0001;
               end
               if (scl_i & (cnt_r + 16'h0001 >= half_c)) begin
                  cnt_r     <= 16'h0000;
                  scl_low_r <= 1'b1;
                  if ((bit_r < iicr_pkg::ACK_BIT) & tx & ~sda_low_r & ~sda_i) begin
                     // Someone else pulled a one we sent low
                     arb_ev_r <= 1'b1;
                  end else if (bit_r == iicr_pkg::ACK_BIT) begin
                     if (tx) begin
                        rxack_r <= sda_i;
                     end else begin
                        rx_data_r <= shift_r;
                     end
                     done_ev_r <= 1'b1;
                     state_r   <= iicr_pkg::ST_WAIT;
                  end else begin
                     shift_r <= {shift_r[6:0], sda_i};
                     bit_r   <= bit_r + 4'h1;
                     state_r <= iicr_pkg::ST_LOW;
                  end
               end
            end
            iicr_pkg::ST_STOP_LOW: begin
               // SDA low under low SCL before the release
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r + 16'h0001 >= half_c) begin
                  scl_low_r <= 1'b0;
                  cnt_r     <= 16'h0000;
                  state_r   <= iicr_pkg::ST_STOP_HOLD;
               end
            end
            iicr_pkg::ST_STOP_HOLD: begin
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r + 16'h0001 >= stoph_c) begin
                  sda_low_r <= 1'b0;
                  cnt_r     <= 16'h0000;
                  state_r   <= iicr_pkg::ST_IDLE;
               end
            end
            iicr_pkg::ST_RS_LOW: begin
               // Release SDA under low SCL, then raise SCL
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r + 16'h0001 == sdah_c) begin
                  sda_low_r <= 1'b0;
               end
               if (cnt_r + 16'h0001 >= half_c) begin
                  sda_low_r <= 1'b0;
                  scl_low_r <= 1'b0;
                  cnt_r     <= 16'h0000;
                  state_r   <= iicr_pkg::ST_RS_HIGH;
               end
            end
            iicr_pkg::ST_RS_HIGH: begin
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r + 16'h0001 >= half_c) begin
                  sda_low_r <= 1'b1;
                  cnt_r     <= 16'h0000;
                  state_r   <= iicr_pkg::ST_START;
               end
            end
            default: begin
               state_r   <= iicr_pkg::ST_IDLE;
               scl_low_r <= 1'b0;
               sda_low_r <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain drive: output always low, enable low while pulling
   assign pins.scl_o    = 1'b0;
   assign pins.scl_oe_n = ~scl_low_r;
   assign pins.sda_o    = 1'b0;
   assign pins.sda_oe_n = ~sda_low_r;

endmodule

// >>> sim/iicr_ctrl_sva.sv
// Checker: port-level assertions on the bus controller top.
`timescale 1ns/1ps
module iicr_ctrl_sva (
   // Clock and reset
   input wire logic                 mclk,
   input wire logic                 srst,
   // APB slave side
   input wire logic [7:0]           paddr,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   // Bus side
   input wire logic                 scl_i,
   input wire logic                 sda_i,
   input wire iicr_pkg::iicr_pins_s pins,
   input wire logic                 irq
);
   logic       acc;    // Access phase
   logic       wr_ctl; // Control write at this edge
   logic       mapped; // Address hits a register
   logic       quiet;  // Interrupt blocked by enable or mask
   logic [7:0] ctl_r;  // Shadow of control bits
   logic [1:0] msk_r;  // Shadow of mask bits
   assign acc = psel && penable;
   assign wr_ctl = acc && pwrite && paddr == iicr_pkg::OFF_CTRL;
   assign mapped = paddr inside {iicr_pkg::OFF_RATE, iicr_pkg::OFF_CTRL, iicr_pkg::OFF_STATUS, iicr_pkg::OFF_MASK,
                                 iicr_pkg::OFF_DATA};
   assign quiet = !ctl_r[iicr_pkg::CTRL_IE] || msk_r == 2'h0;
   // Shadow control; misses the hardware clear on arbitration loss, so start checks only fresh writes
   always_ff @(posedge mclk) begin
      if (srst) begin
         ctl_r <= 8'h00;
      end else if (wr_ctl) begin
         ctl_r <= pwdata[7:0];
      end
   end
   // Shadow mask
   always_ff @(posedge mclk) begin
      if (srst) begin
         msk_r <= 2'h0;
      end else if (acc && pwrite && paddr == iicr_pkg::OFF_MASK) begin
         msk_r <= pwdata[1:0];
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   rdy_ans_a: assert property (acc |-> pready)
      else $error("no ready in access phase");
   map_err_a: assert property (acc |-> pslverr == !mapped)
      else $error("error response does not match the map");
   rd_hold_a: assert property (!psel && !$past(psel) |-> $stable(prdata))
      else $error("read data moved while idle");
   rs_zero_a: assert property (acc && !pwrite && paddr == iicr_pkg::OFF_CTRL |-> !prdata[iicr_pkg::CTRL_RS])
      else $error("repeat bit read as one");
   rst_idle_a: assert property (disable iff (1'b0) srst |=> pins.scl_oe_n && pins.sda_oe_n && !irq)
      else $error("lines or interrupt active after reset");
   off_free_a: assert property (!ctl_r[7] && !$past(ctl_r[7]) |-> pins.scl_oe_n && pins.sda_oe_n)
      else $error("disabled controller drives the bus");
   irq_gate_a: assert property (quiet && $past(quiet) |-> !irq)
      else $error("interrupt raised while gated");
   start_go_a: assert property (wr_ctl && pwdata[7] && pwdata[5] && !ctl_r[5] |->
      ##[1:4] !pins.sda_oe_n && pins.scl_oe_n)
      else $error("no start after master select");
   cover property (wr_ctl && pwdata[iicr_pkg::CTRL_MS]);
   cover property (irq);
   cover property (acc && pslverr);
endmodule

// >>> sim/iicr_bus_model.sv
// Partner model: a bus slave that acknowledges every ninth clock pulse.
`timescale 1ns/1ps
module iicr_bus_model (
   // Wire levels
   input  wire logic scl,
   input  wire logic sda,
   // Acknowledge on or off
   input  wire logic ack_en,
   // Pull on the data wire
   output logic      sda_pull
);
   int rise_n; // Clock pulses since start, back to zero after the ninth
   initial begin
      rise_n = 0;
      sda_pull = 1'b0;
   end
   // Start restarts the count; own ack pull happens with the clock low, so never seen here
   always @(negedge sda) begin
      if (scl) begin
         rise_n = 0;
         sda_pull = 1'b0;
      end
   end
   // Count clock pulses
   always @(posedge scl) rise_n++;
   // Pull data low through the ninth pulse only
   always @(negedge scl) begin
      sda_pull = ack_en && rise_n == 8;
      if (rise_n == 9) begin
         rise_n = 0;
      end
   end
endmodule

// >>> sim/iicr_ctrl_tb.sv
// Testbench: registers, rate timing, interrupt and control scenarios of the bus controller.
`timescale 1ns/1ps
module iicr_ctrl_tb;
   logic                 mclk, srst, psel, penable, pwrite, pready, pslverr, irq, ack_en, m_sda, err;
   logic [7:0]           paddr;
   logic [31:0]          pwdata, prdata, q;
   wire                  scl, sda; // Open-drain wires with pull-ups
   iicr_pkg::iicr_pins_s pins;
   int                   err_total, checks, cyc;
   assign scl = pins.scl_oe_n;
   assign sda = pins.sda_oe_n & ~m_sda;
   iicr_ctrl i_iicr_ctrl (.mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .pins(pins),
      .irq(irq));
   iicr_bus_model i_iicr_bus_model (.scl(scl), .sda(sda), .ack_en(ack_en), .sda_pull(m_sda));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         finish_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask
   // One APB transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_reg();
      apb(0, iicr_pkg::OFF_CTRL, 32'h0);
      chk("ctrl reset", {24'h0, iicr_pkg::RST_CTRL}, q);
      apb(0, iicr_pkg::OFF_RATE, 32'h0);
      chk("rate reset", {24'h0, iicr_pkg::RST_RATE}, q);
      apb(1, 8'h40, 32'hFF);
      chk("slverr", 32'h1, {31'h0, err});
      apb(0, 8'h40, 32'h0);
      chk("unmapped read", 32'h0, q);
   endtask
   // Start hold and stop hold in clock cycles
   task automatic t_rate(input logic [31:0] r, input int st, input int sp);
      int n;
      apb(1, iicr_pkg::OFF_RATE, r);
      apb(1, iicr_pkg::OFF_CTRL, 32'hB0);
      while (sda) @(posedge mclk);
      n = 0;
      while (scl) begin @(posedge mclk); n++; end
      chk("start hold", st, n);
      apb(1, iicr_pkg::OFF_CTRL, 32'h90);
      while (!scl) @(posedge mclk);
      n = 0;
      while (!sda) begin @(posedge mclk); n++; end
      chk("stop hold", sp, n);
   endtask
   task automatic t_byte();
      int n;
      logic [7:0] b;
      apb(1, iicr_pkg::OFF_RATE, 32'h20);
      apb(1, iicr_pkg::OFF_MASK, 32'h3);
      apb(1, iicr_pkg::OFF_CTRL, 32'hF0);
      while (scl) @(posedge mclk);
      apb(1, iicr_pkg::OFF_DATA, 32'hA5);
      for (int i = 0; i < 8; i++) begin
         while (!scl) @(posedge mclk);
         b = {b[6:0], sda};
         n = 0;
         while (scl) begin @(posedge mclk); n++; end
      end
      chk("tx byte", 32'hA5, {24'h0, b});
      chk("scl high", 32'h1, {31'h0, n >= 80 && n <= 82});
      while (irq !== 1'b1) @(posedge mclk);
      apb(0, iicr_pkg::OFF_STATUS, 32'h0);
      chk("status", 32'h11, q);
      apb(1, iicr_pkg::OFF_CTRL, 32'hB0);
      @(posedge mclk);
      chk("irq off", 32'h0, {31'h0, irq});
      apb(1, iicr_pkg::OFF_CTRL, 32'hF0);
      @(posedge mclk);
      chk("irq on", 32'h1, {31'h0, irq});
      apb(1, iicr_pkg::OFF_STATUS, 32'h1);
      @(posedge mclk);
      chk("irq clear", 32'h0, {31'h0, irq});
      apb(1, iicr_pkg::OFF_CTRL, 32'hF4);
      while (!scl) @(posedge mclk);
      while (sda) @(posedge mclk);
      chk("restart", 32'h1, {31'h0, scl});
      apb(0, iicr_pkg::OFF_CTRL, 32'h0);
      chk("ctrl read", 32'hF0, q);
      ack_en <= 1'b0;
      apb(1, iicr_pkg::OFF_CTRL, 32'hE0);
      // Receive trigger only counts once the start has parked SCL low
      while (scl) @(posedge mclk);
      apb(0, iicr_pkg::OFF_DATA, 32'h0);
      for (int i = 0; i < 9; i++) begin
         while (!scl) @(posedge mclk);
         if (i < 8) while (scl) @(posedge mclk);
      end
      chk("ack drive", 32'h0, {31'h0, sda});
      while (irq !== 1'b1) @(posedge mclk);
      apb(1, iicr_pkg::OFF_CTRL, 32'hF0);
      apb(0, iicr_pkg::OFF_DATA, 32'h0);
      chk("rx byte", 32'hFF, q);
      apb(1, iicr_pkg::OFF_CTRL, 32'h80);
      while (!scl) @(posedge mclk);
      while (!sda) @(posedge mclk);
      chk("stop level", 32'h1, {31'h0, scl});
   endtask
   task automatic t_arb();
      apb(1, iicr_pkg::OFF_STATUS, 32'h3);
      apb(1, iicr_pkg::OFF_CTRL, 32'h84);
      apb(0, iicr_pkg::OFF_STATUS, 32'h0);
      chk("arb lost", 32'h2, q);
   endtask
   task automatic t_off();
      apb(1, iicr_pkg::OFF_RATE, 32'h3F);
      apb(1, iicr_pkg::OFF_CTRL, 32'hB0);
      while (sda) @(posedge mclk);
      apb(1, iicr_pkg::OFF_CTRL, 32'h30);
      repeat (2) @(posedge mclk);
      chk("lines free", 32'h3, {30'h0, scl, sda});
      apb(0, iicr_pkg::OFF_STATUS, 32'h0);
      chk("busy", 32'h0, q & 32'h10);
   endtask
   task automatic finish_test();
      if (err_total == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      srst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      ack_en = 1'b1;
      err_total = 0;
      checks = 0;
      cyc = 0;
      repeat (8) @(posedge mclk);
      srst <= 1'b0;
      t_reg();
      t_rate(32'h20, 78, 81);
      t_rate(32'h3F, 1918, 1921);
      t_rate(32'h60, 156, 162);
      t_rate(32'hA0, 312, 324);
      t_byte();
      t_arb();
      t_off();
      finish_test();
   end
endmodule
bind iicr_ctrl iicr_ctrl_sva i_iicr_ctrl_sva (.mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_i(scl_i), .sda_i(sda_i), .pins(pins), .irq(irq));
